// ===== common/sdio_pkg.sv
// Constants, register map and carrier types of the step drive I/O block
// Overview of operation
// - Enable acts on rising edge, powers bridge
// - Enable rising edge clears latched resettable faults
// - Enable active at power-up keeps drive disabled
// - Enable hold source: input, AND, OR, software; enable edge always from input
// - Fast inputs accept up to 2 MHz
// - Step/dir: A direction, step on B fall
// - Step plus/minus: pulse A ccw, B cw
// - Quadrature: A rising, B low is ccw
// - Fast input filter 30k, 250k, 2M
// - Analog value: velocity command or program read
// - Default output: healthy when no fault
// - Output switchable to brake release role
// - Brake: powered, enabled and fault free
// - Brake asserts 200 ms after enable edge
// - Brake drops at once on fault/disable
package sdio_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned BRAKE_DELAY_MS = 200;
  localparam int unsigned BRAKE_DELAY_CYC = CLK_HZ / 1000 * BRAKE_DELAY_MS;
  localparam int unsigned FILT_30K_HZ = 30000;
  localparam int unsigned FILT_250K_HZ = 250000;
  localparam int unsigned FILT_2M_HZ = 2000000;
  // Stable cycles needed: half period of the cutoff, rounded down, at least one
  localparam int unsigned FILT_30K_CYC = CLK_HZ / (2 * FILT_30K_HZ);
  localparam int unsigned FILT_250K_CYC = CLK_HZ / (2 * FILT_250K_HZ);
  localparam int unsigned FILT_2M_CYC = CLK_HZ / (2 * FILT_2M_HZ);
  localparam int unsigned ANALOG_W = 10;

  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h08;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h0c;
  localparam logic [7:0] POS_ADDR = 8'h10;
  localparam logic [7:0] ANALOG_ADDR = 8'h14;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  // Enable synchroniser starts at the active level, so a held input is no edge
  localparam logic [2:0] EN_SYNC_RST = 3'h7;

  // Event bits of the interrupt status register
  localparam int unsigned EV_ENABLE = 0;
  localparam int unsigned EV_FAULT = 1;
  localparam int unsigned EV_STEP = 2;
  localparam int unsigned EV_BRAKE = 3;
  localparam int unsigned EV_W = 4;

  typedef enum logic [1:0] {SDIO_EN_INPUT, SDIO_EN_AND, SDIO_EN_OR, SDIO_EN_SOFT} sdio_en_src_t;
  typedef enum logic [1:0] {SDIO_DEC_STEP_DIR, SDIO_DEC_PLUS_MINUS, SDIO_DEC_QUAD, SDIO_DEC_OFF}
    sdio_decode_t;
  typedef enum logic [1:0] {SDIO_FILT_2M, SDIO_FILT_250K, SDIO_FILT_30K, SDIO_FILT_NONE}
    sdio_filter_t;

  // Control register layout, bit 31 downward to bit 0
  typedef struct packed {
    logic [22:0] unused;
    logic analog_as_velocity;
    logic brake_role;
    logic [1:0] fast_input_filter_select;
    logic [1:0] decode_mode;
    logic [1:0] enable_source;
    logic soft_enable_bit;
  } sdio_ctrl_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } sdio_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sdio_apb_rsp_t;
endpackage

// ===== src/sdio_top.sv
// Step drive control inputs, fast command decoder and healthy/brake output
`timescale 1ns/1ps
module sdio_top #(
  parameter int unsigned BRAKE_DELAY_CYCLES = sdio_pkg::BRAKE_DELAY_CYC,
  parameter int unsigned POS_W = 32
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire sdio_pkg::sdio_apb_req_t apb_req,
  output sdio_pkg::sdio_apb_rsp_t apb_rsp,
  input wire logic enable_input,
  input wire logic fast_input_a,
  input wire logic fast_input_b,
  input wire logic [sdio_pkg::ANALOG_W-1:0] analog_command_value,
  input wire logic main_power_ok,
  input wire logic fault_event,
  input wire logic fault_active,
  output logic bridge_on,
  output logic faults_latched,
  output logic special_output,
  output logic step_pulse,
  output logic step_clockwise,
  output logic [sdio_pkg::ANALOG_W-1:0] velocity_command,
  output logic irq
);
  localparam int unsigned CNT_W = 32;

  typedef struct packed {
    logic [2:0] sync_en;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic filt_a;
    logic filt_b;
    logic [15:0] filt_cnt_a;
    logic [15:0] filt_cnt_b;
    logic armed;
    logic enabled;
    logic fault_latch;
    logic [CNT_W-1:0] brake_cnt;
    logic brake;
    logic step;
    logic step_cw;
    logic [POS_W-1:0] position;
    logic [sdio_pkg::ANALOG_W-1:0] velocity;
    sdio_pkg::sdio_ctrl_t ctrl;
    logic [sdio_pkg::EV_W-1:0] irq_stat;
    logic [sdio_pkg::EV_W-1:0] irq_mask;
    logic [31:0] prdata;
  } sdio_state_t;

  sdio_state_t state;
  sdio_state_t next_state;

  function automatic logic [15:0] sdio_filt_limit(input logic [1:0] sel);
    unique case (sel)
      2'd0: sdio_filt_limit = 16'(sdio_pkg::FILT_2M_CYC);
      2'd1: sdio_filt_limit = 16'(sdio_pkg::FILT_250K_CYC);
      2'd2: sdio_filt_limit = 16'(sdio_pkg::FILT_30K_CYC);
      default: sdio_filt_limit = 16'h0000;
    endcase
  endfunction

  logic [15:0] filt_limit;
  logic en_rise;
  logic en_level;
  logic a_fall;
  logic a_rise;
  logic b_fall;
  logic b_rise;
  logic step_now;
  logic cw_now;
  logic wr_acc;
  logic rd_acc;
  logic [sdio_pkg::EV_W-1:0] events;

  assign filt_limit = sdio_filt_limit(state.ctrl.fast_input_filter_select);
  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_acc = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  // Edges taken from the second and third flops only
  assign en_rise = state.sync_en[1] && !state.sync_en[2];
  always_comb
  begin
    next_state = state;
    step_now = 1'b0;
    cw_now = state.step_cw;
    events = '0;
    next_state.sync_en = {state.sync_en[1:0], enable_input};
    next_state.sync_a = {state.sync_a[1:0], fast_input_a};
    next_state.sync_b = {state.sync_b[1:0], fast_input_b};
    // Filter: a level is taken once stable for the selected count
    if (state.sync_a[1] == state.filt_a)
      next_state.filt_cnt_a = '0;
    else if (state.filt_cnt_a >= filt_limit)
    begin
      next_state.filt_a = state.sync_a[1];
      next_state.filt_cnt_a = '0;
    end
    else
      next_state.filt_cnt_a = state.filt_cnt_a + 16'h0001;
    if (state.sync_b[1] == state.filt_b)
      next_state.filt_cnt_b = '0;
    else if (state.filt_cnt_b >= filt_limit)
    begin
      next_state.filt_b = state.sync_b[1];
      next_state.filt_cnt_b = '0;
    end
    else
      next_state.filt_cnt_b = state.filt_cnt_b + 16'h0001;
    // Edges of the filtered levels
    a_rise = next_state.filt_a && !state.filt_a;
    a_fall = !next_state.filt_a && state.filt_a;
    b_rise = next_state.filt_b && !state.filt_b;
    b_fall = !next_state.filt_b && state.filt_b;
    // Input must be seen low once after reset before a rising edge counts
    if (!state.sync_en[2])
      next_state.armed = 1'b1;
    unique case (sdio_pkg::sdio_en_src_t'(state.ctrl.enable_source))
      sdio_pkg::SDIO_EN_INPUT: en_level = state.sync_en[2];
      sdio_pkg::SDIO_EN_AND: en_level = state.sync_en[2] && state.ctrl.soft_enable_bit;
      sdio_pkg::SDIO_EN_OR: en_level = state.sync_en[2] || state.ctrl.soft_enable_bit;
      sdio_pkg::SDIO_EN_SOFT: en_level = state.ctrl.soft_enable_bit;
    endcase
    if (en_rise && state.armed && !fault_active)
    begin
      next_state.enabled = 1'b1;
      next_state.fault_latch = 1'b0;
      next_state.brake_cnt = CNT_W'(BRAKE_DELAY_CYCLES);
      events[sdio_pkg::EV_ENABLE] = 1'b1;
    end
    else if (state.enabled && (!en_level || fault_active || state.fault_latch))
      next_state.enabled = 1'b0;
    if (en_rise && state.armed)
      next_state.fault_latch = 1'b0;
    if (fault_event)
    begin
      next_state.fault_latch = 1'b1;
      next_state.enabled = 1'b0;
      events[sdio_pkg::EV_FAULT] = 1'b1;
    end
    // Brake delay counts down only while still enabled and fault free
    if (!next_state.enabled || !main_power_ok || fault_active || fault_event)
    begin
      next_state.brake = 1'b0;
      next_state.brake_cnt = '0;
    end
    else if (state.brake_cnt > CNT_W'(1))
      next_state.brake_cnt = state.brake_cnt - CNT_W'(1);
    else if (state.brake_cnt == CNT_W'(1))
    begin
      next_state.brake_cnt = '0;
      next_state.brake = 1'b1;
      events[sdio_pkg::EV_BRAKE] = 1'b1;
    end
    // Command decode from the filtered fast inputs
    unique case (sdio_pkg::sdio_decode_t'(state.ctrl.decode_mode))
      sdio_pkg::SDIO_DEC_STEP_DIR:
      begin
        step_now = b_fall;
        cw_now = next_state.filt_a;
      end
      sdio_pkg::SDIO_DEC_PLUS_MINUS:
      begin
        if (a_rise && !next_state.filt_b)
        begin
          step_now = 1'b1;
          cw_now = 1'b0;
        end
        else if (b_rise && !next_state.filt_a)
        begin
          step_now = 1'b1;
          cw_now = 1'b1;
        end
      end
      sdio_pkg::SDIO_DEC_QUAD:
      begin
        if (a_rise || a_fall)
        begin
          step_now = 1'b1;
          cw_now = next_state.filt_a ? next_state.filt_b : !next_state.filt_b;
        end
        else if (b_rise || b_fall)
        begin
          step_now = 1'b1;
          cw_now = next_state.filt_b ? !next_state.filt_a : next_state.filt_a;
        end
      end
      sdio_pkg::SDIO_DEC_OFF: step_now = 1'b0;
    endcase
    next_state.step = step_now && state.enabled;
    next_state.step_cw = cw_now;
    if (step_now && state.enabled)
    begin
      next_state.position = cw_now ? state.position + POS_W'(1) : state.position - POS_W'(1);
      events[sdio_pkg::EV_STEP] = 1'b1;
    end
    if (state.ctrl.analog_as_velocity)
      next_state.velocity = analog_command_value;
    else
      next_state.velocity = '0;
    // Register writes
    if (wr_acc)
    begin
      unique case (apb_req.paddr)
        sdio_pkg::CTRL_ADDR: next_state.ctrl = apb_req.pwdata;
        sdio_pkg::IRQ_STAT_ADDR:
          next_state.irq_stat = state.irq_stat & ~apb_req.pwdata[sdio_pkg::EV_W-1:0];
        sdio_pkg::IRQ_MASK_ADDR: next_state.irq_mask = apb_req.pwdata[sdio_pkg::EV_W-1:0];
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    next_state.irq_stat = next_state.irq_stat | events;
    if (rd_acc)
    begin
      unique case (apb_req.paddr)
        sdio_pkg::CTRL_ADDR: next_state.prdata = state.ctrl;
        sdio_pkg::STATUS_ADDR:
          next_state.prdata = {26'h0, state.armed, state.step_cw, state.brake,
            main_power_ok, state.fault_latch, state.enabled};
        sdio_pkg::IRQ_STAT_ADDR: next_state.prdata = {28'h0, state.irq_stat};
        sdio_pkg::IRQ_MASK_ADDR: next_state.prdata = {28'h0, state.irq_mask};
        sdio_pkg::POS_ADDR: next_state.prdata = 32'(state.position);
        sdio_pkg::ANALOG_ADDR: next_state.prdata = {22'h0, analog_command_value};
        default: next_state.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= '0;
      state.sync_en <= sdio_pkg::EN_SYNC_RST;
      state.ctrl <= sdio_pkg::CTRL_RST;
      state.irq_mask <= sdio_pkg::MASK_RST[sdio_pkg::EV_W-1:0];
    end
    else
      state <= next_state;
  end

  logic addr_hit;
  always_comb
  begin
    unique case (apb_req.paddr)
      sdio_pkg::CTRL_ADDR, sdio_pkg::STATUS_ADDR, sdio_pkg::IRQ_STAT_ADDR,
      sdio_pkg::IRQ_MASK_ADDR, sdio_pkg::POS_ADDR, sdio_pkg::ANALOG_ADDR: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_hit;
  assign apb_rsp.prdata = state.prdata;
  assign bridge_on = state.enabled;
  assign faults_latched = state.fault_latch;
  // Healthy by default, brake release when reconfigured
  assign special_output = state.ctrl.brake_role
    ? (state.brake && main_power_ok && !fault_active)
    : (main_power_ok && !fault_active && !state.fault_latch);
  assign step_pulse = state.step;
  assign step_clockwise = state.step_cw;
  assign velocity_command = state.velocity;
  assign irq = |(state.irq_stat & state.irq_mask);

  a_brake_needs_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state.ctrl.brake_role && special_output)
      |-> state.enabled && main_power_ok && !fault_active)
    else $error("brake released while disabled or unpowered");
  a_brake_drop_fast: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state.brake && fault_event) |=> !state.brake)
    else $error("brake not dropped at fault");
  a_enable_on_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(state.enabled) |-> $past(en_rise) && $past(state.armed))
    else $error("enabled without rising edge");
  a_fault_clear_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
    (en_rise && state.armed && !fault_event) |=> !state.fault_latch)
    else $error("fault not cleared by enable edge");
  a_powerup_armed: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state.enabled && !$past(state.enabled)) |-> $past(state.armed))
    else $error("enabled before input seen inactive");
  a_soft_src_en: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state.enabled && state.ctrl.enable_source == 2'd3 && !state.ctrl.soft_enable_bit
      && !en_rise) |=> !state.enabled)
    else $error("soft source off did not disable");
  a_step_dir_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state.ctrl.decode_mode == 2'd0 && state.enabled && b_fall) |=> state.step)
    else $error("no step on falling step input");
  a_healthy_out: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!state.ctrl.brake_role && fault_active) |-> !special_output)
    else $error("healthy output during fault");
  a_brake_delay: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(state.brake) |-> state.brake_cnt == '0 && $past(state.brake_cnt) == CNT_W'(1))
    else $error("brake released without full delay");
endmodule

// ===== verif/sdio_motion_ctrl.sv
// Model of the external motion controller that drives enable and fast inputs
`timescale 1ns/1ps
module sdio_motion_ctrl #(
  parameter logic EN_AT_POWER_UP = 1'b1
) (
  input wire logic core_clk,
  output logic enable_input,
  output logic fast_input_a,
  output logic fast_input_b
);
  initial
  begin
    enable_input = EN_AT_POWER_UP;
    fast_input_a = 1'b0;
    fast_input_b = 1'b0;
  end

  // Enable level change, held long enough for the synchronizer to see it
  task automatic set_en(input logic v);
    @(posedge core_clk);
    enable_input <= v;
    repeat (10) @(posedge core_clk);
  endtask

  // Holds of 10 clocks keep transitions inside the 2 MHz input limit
  task automatic set_ab(input logic a, input logic b, input int hold);
    @(posedge core_clk);
    fast_input_a <= a;
    fast_input_b <= b;
    repeat (hold) @(posedge core_clk);
  endtask
endmodule

// ===== verif/sdio_top_bench.sv
// Self-checking bench for the step drive I/O block
`timescale 1ns/1ps
module sdio_top_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  sdio_pkg::sdio_apb_req_t apb_req;
  sdio_pkg::sdio_apb_rsp_t apb_rsp;
  logic enable_input;
  logic fast_input_a;
  logic fast_input_b;
  logic [sdio_pkg::ANALOG_W-1:0] analog_command_value;
  logic main_power_ok;
  logic fault_event;
  logic fault_active;
  logic bridge_on;
  logic faults_latched;
  logic special_output;
  logic step_pulse;
  logic step_clockwise;
  logic [sdio_pkg::ANALOG_W-1:0] velocity_command;
  logic irq;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int samples_checked = 0;
  int steps_seen = 0;

  always #20 core_clk = ~core_clk;

  // Counts one-cycle step pulses
  always @(posedge core_clk)
    if (step_pulse === 1'b1)
      steps_seen++;

  sdio_top #(.BRAKE_DELAY_CYCLES(20)) i_sdio_top (
    .core_clk(core_clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .enable_input(enable_input), .fast_input_a(fast_input_a), .fast_input_b(fast_input_b),
    .analog_command_value(analog_command_value), .main_power_ok(main_power_ok),
    .fault_event(fault_event), .fault_active(fault_active), .bridge_on(bridge_on),
    .faults_latched(faults_latched), .special_output(special_output),
    .step_pulse(step_pulse), .step_clockwise(step_clockwise),
    .velocity_command(velocity_command), .irq(irq)
  );

  sdio_motion_ctrl i_sdio_motion_ctrl (
    .core_clk(core_clk), .enable_input(enable_input),
    .fast_input_a(fast_input_a), .fast_input_b(fast_input_b)
  );

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (apb_rsp.pready !== 1'b1 && n < 50);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    check("pready", {31'h0, apb_rsp.pready}, 32'h1);
    if (n >= 50)
      end_sim();
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  task automatic ab(input logic a, input logic b);
    i_sdio_motion_ctrl.set_ab(a, b, 10);
  endtask

  task automatic en_cycle();
    i_sdio_motion_ctrl.set_en(1'b0);
    i_sdio_motion_ctrl.set_en(1'b1);
  endtask

  task automatic pos_chk(input logic [31:0] exp);
    idle(20);
    rd_chk("position", sdio_pkg::POS_ADDR, exp);
  endtask

  // Bounded wait on bridge_on (sel 0) or special_output (sel 1)
  task automatic wait_for(input string what, input bit sel, input logic v);
    int n;
    n = 0;
    while ((sel ? special_output : bridge_on) !== v && n < 60)
    begin
      idle(1);
      n++;
    end
    check(what, {31'h0, sel ? special_output : bridge_on}, {31'h0, v});
    if (n >= 60)
      end_sim();
  endtask

  initial
  begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    $display("[FAIL] run time expected end seen limit");
    end_sim();
  end

  initial
  begin
    apb_req <= '0;
    analog_command_value <= '0;
    main_power_ok <= 1'b1;
    fault_event <= 1'b0;
    fault_active <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    idle(30);
    check("bridge_on", {31'h0, bridge_on}, 32'h0);
    check("special_output", {31'h0, special_output}, 32'h1);
    rd_chk("ctrl", sdio_pkg::CTRL_ADDR, sdio_pkg::CTRL_RST);
    rd_chk("irq_mask", sdio_pkg::IRQ_MASK_ADDR, sdio_pkg::MASK_RST);
    apb(1'b1, 8'h20, 32'h1);
    check("pslverr", {31'h0, err}, 32'h1);
    $display("test reset done");
    en_cycle();
    wait_for("bridge_on", 1'b0, 1'b1);
    rd_chk("irq_stat", sdio_pkg::IRQ_STAT_ADDR, 32'h1 << sdio_pkg::EV_ENABLE);
    apb(1'b1, sdio_pkg::IRQ_MASK_ADDR, 32'h1);
    idle(2);
    check("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, sdio_pkg::IRQ_STAT_ADDR, 32'h1);
    idle(2);
    check("irq", {31'h0, irq}, 32'h0);
    apb(1'b1, sdio_pkg::IRQ_MASK_ADDR, 32'h0);
    $display("test enable done");
    apb(1'b1, sdio_pkg::CTRL_ADDR, 32'h60);
    ab(1'b1, 1'b1);
    ab(1'b1, 1'b0);
    pos_chk(32'h1);
    check("step_clockwise", {31'h0, step_clockwise}, 32'h1);
    ab(1'b0, 1'b1);
    ab(1'b0, 1'b0);
    pos_chk(32'h0);
    apb(1'b1, sdio_pkg::CTRL_ADDR, 32'h68);
    ab(1'b1, 1'b0);
    ab(1'b0, 1'b0);
    pos_chk(32'hffffffff);
    ab(1'b0, 1'b1);
    ab(1'b0, 1'b0);
    pos_chk(32'h0);
    apb(1'b1, sdio_pkg::CTRL_ADDR, 32'h70);
    ab(1'b1, 1'b0);
    ab(1'b1, 1'b1);
    ab(1'b0, 1'b1);
    ab(1'b0, 1'b0);
    pos_chk(32'hfffffffc);
    apb(1'b1, sdio_pkg::CTRL_ADDR, 32'h00);
    i_sdio_motion_ctrl.set_ab(1'b1, 1'b1, 3);
    ab(1'b1, 1'b0);
    pos_chk(32'hfffffffc);
    ab(1'b1, 1'b1);
    ab(1'b1, 1'b0);
    pos_chk(32'hfffffffd);
    apb(1'b1, sdio_pkg::CTRL_ADDR, 32'h20);
    i_sdio_motion_ctrl.set_ab(1'b1, 1'b1, 30);
    ab(1'b1, 1'b0);
    pos_chk(32'hfffffffd);
    i_sdio_motion_ctrl.set_ab(1'b1, 1'b1, 60);
    i_sdio_motion_ctrl.set_ab(1'b1, 1'b0, 60);
    pos_chk(32'hfffffffe);
    apb(1'b1, sdio_pkg::CTRL_ADDR, 32'h40);
    i_sdio_motion_ctrl.set_ab(1'b1, 1'b1, 300);
    ab(1'b1, 1'b0);
    pos_chk(32'hfffffffe);
    i_sdio_motion_ctrl.set_ab(1'b1, 1'b1, 450);
    i_sdio_motion_ctrl.set_ab(1'b1, 1'b0, 450);
    pos_chk(32'hffffffff);
    apb(1'b1, sdio_pkg::CTRL_ADDR, 32'h18);
    ab(1'b1, 1'b1);
    ab(1'b1, 1'b0);
    pos_chk(32'hffffffff);
    check("step_pulse count", steps_seen, 32'd11);
    $display("test decode done");
    @(posedge core_clk) analog_command_value <= 10'h2a5;
    apb(1'b1, sdio_pkg::CTRL_ADDR, 32'h100);
    idle(3);
    check("velocity_command", {22'h0, velocity_command}, 32'h2a5);
    rd_chk("analog", sdio_pkg::ANALOG_ADDR, 32'h2a5);
    apb(1'b1, sdio_pkg::CTRL_ADDR, 32'h0);
    idle(3);
    check("velocity_command", {22'h0, velocity_command}, 32'h0);
    $display("test analog done");
    @(posedge core_clk) fault_event <= 1'b1;
    @(posedge core_clk) fault_event <= 1'b0;
    wait_for("bridge_on", 1'b0, 1'b0);
    check("faults_latched", {31'h0, faults_latched}, 32'h1);
    check("special_output", {31'h0, special_output}, 32'h0);
    rd_chk("irq_stat", sdio_pkg::IRQ_STAT_ADDR, 32'he);
    apb(1'b1, sdio_pkg::IRQ_STAT_ADDR, 32'hf);
    en_cycle();
    wait_for("bridge_on", 1'b0, 1'b1);
    check("faults_latched", {31'h0, faults_latched}, 32'h0);
    check("special_output", {31'h0, special_output}, 32'h1);
    @(posedge core_clk) main_power_ok <= 1'b0;
    idle(2);
    check("special_output", {31'h0, special_output}, 32'h0);
    @(posedge core_clk) main_power_ok <= 1'b1;
    $display("test fault done");
    apb(1'b1, sdio_pkg::CTRL_ADDR, 32'h80);
    i_sdio_motion_ctrl.set_en(1'b0);
    wait_for("bridge_on", 1'b0, 1'b0);
    check("special_output", {31'h0, special_output}, 32'h0);
    i_sdio_motion_ctrl.set_en(1'b1);
    idle(1);
    check("special_output", {31'h0, special_output}, 32'h0);
    wait_for("special_output", 1'b1, 1'b1);
    @(posedge core_clk) fault_active <= 1'b1;
    idle(2);
    check("special_output", {31'h0, special_output}, 32'h0);
    @(posedge core_clk) fault_active <= 1'b0;
    $display("test brake done");
    apb(1'b1, sdio_pkg::CTRL_ADDR, 32'h05);
    en_cycle();
    wait_for("bridge_on", 1'b0, 1'b1);
    i_sdio_motion_ctrl.set_en(1'b0);
    check("bridge_on", {31'h0, bridge_on}, 32'h1);
    apb(1'b1, sdio_pkg::CTRL_ADDR, 32'h03);
    wait_for("bridge_on", 1'b0, 1'b0);
    i_sdio_motion_ctrl.set_en(1'b1);
    wait_for("bridge_on", 1'b0, 1'b1);
    apb(1'b1, sdio_pkg::CTRL_ADDR, 32'h02);
    wait_for("bridge_on", 1'b0, 1'b0);
    apb(1'b1, sdio_pkg::CTRL_ADDR, 32'h07);
    en_cycle();
    wait_for("bridge_on", 1'b0, 1'b1);
    i_sdio_motion_ctrl.set_en(1'b0);
    check("bridge_on", {31'h0, bridge_on}, 32'h1);
    apb(1'b1, sdio_pkg::CTRL_ADDR, 32'h06);
    wait_for("bridge_on", 1'b0, 1'b0);
    $display("test source done");
    end_sim();
  end
endmodule
